// *** include/tlbm_pkg.sv ***
/*
 * Shared constants and types for the TLB maintenance block: APB register
 * offsets, field positions, reset values, opcode fields and entry layout.
 * Assumes a 32-bit APB register bus and a single core clock domain.
 */
`default_nettype none
package tlbm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_INSN = 8'h00;
	localparam logic [7:0] OFF_TAG = 8'h04;
	localparam logic [7:0] OFF_EVEN = 8'h08;
	localparam logic [7:0] OFF_ODD = 8'h0C;
	localparam logic [7:0] OFF_PMASK = 8'h10;
	localparam logic [7:0] OFF_INDEX = 8'h14;
	localparam logic [7:0] OFF_CFG = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_IRQMASK = 8'h20;

	// Instruction fields
	localparam logic [5:0] MAJOR_GROUP = 6'h00;
	localparam logic [5:0] MINOR_SUBGROUP = 6'h3C;
	localparam logic [9:0] MINOR_PROBE = 10'h00D;
	localparam logic [9:0] MINOR_READ = 10'h04D;
	localparam logic [9:0] MINOR_WRITE = 10'h08D;

	// Translation tag fields
	localparam int TAG_VIRTUAL_PAGE_PAIR_TAG_LSB = 13;
	localparam int TAG_INV_BIT = 10;
	// Page mapping fields
	localparam int MAP_PFN_LSB = 6;
	localparam int MAP_C_LSB = 3;
	localparam int MAP_D_BIT = 2;
	localparam int MAP_V_BIT = 1;
	localparam int MAP_G_BIT = 0;
	// Page mask field
	localparam int PMASK_LSB = 13;
	// Entry pointer miss flag
	localparam int INDEX_MISS_BIT = 31;

	// Configuration bits
	localparam int CFG_IE_LSB = 0;
	localparam int CFG_REL3_BIT = 2;
	localparam int CFG_CP0EN_BIT = 3;
	localparam int CFG_ZMASK_BIT = 4;
	localparam logic [31:0] CFG_RST = 32'h0000_0008;

	// Status / mask bits
	localparam int ST_W = 5;
	localparam int ST_DONE = 0;
	localparam int ST_MISS = 1;
	localparam int ST_CPU = 2;
	localparam int ST_MCHK = 3;
	localparam int ST_RSVD = 4;

	localparam logic [31:0] REG_RST = 32'h0000_0000;

	typedef enum {OP_NONE, OP_PROBE, OP_READ, OP_WRITE} tlbm_op_t;

	typedef struct packed {
		logic dead;
		logic [18:0] virtual_page_pair_tag;
		logic [7:0] asid;
		logic g;
		logic [15:0] mask;
		logic [19:0] pfn0;
		logic [2:0] c0;
		logic d0;
		logic v0;
		logic [19:0] pfn1;
		logic [2:0] c1;
		logic d1;
		logic v1;
	} tlbm_entry_t;

	localparam tlbm_entry_t ENTRY_RST = '{dead: 1'b1, default: '0};

endpackage
`default_nettype wire

// *** logic/tlbm_decode.sv ***
/*
 * Instruction decoder for the three TLB maintenance operations.
 * Assumes the word arrives already aligned as a 32-bit instruction.
 */
`timescale 1ns/1ps
`default_nettype none
module tlbm_decode (
	input wire logic [31:0] insn,
	output var tlbm_pkg::tlbm_op_t op,
	output logic known
);
	import tlbm_pkg::*;

	// Common frame: major group, zero code field, subgroup
	wire frame_ok = insn[31:26] == MAJOR_GROUP && insn[25:16] == 10'h000 &&
		insn[5:0] == MINOR_SUBGROUP;
	wire is_probe = frame_ok && insn[15:6] == MINOR_PROBE; // see RULE1
	wire is_read = frame_ok && insn[15:6] == MINOR_READ; // see RULE2
	wire is_write = frame_ok && insn[15:6] == MINOR_WRITE; // see RULE3

	assign known = is_probe | is_read | is_write;
	assign op = is_probe ? OP_PROBE : is_read ? OP_READ :
		is_write ? OP_WRITE : OP_NONE;
endmodule
`default_nettype wire

// *** logic/tlbm_match.sv ***
/*
 * One entry comparator: page pair under mask, address space or global.
 * Assumes entry fields are stable for the whole cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module tlbm_match (
	input wire tlbm_pkg::tlbm_entry_t ent,
	input wire logic [18:0] virtual_page_pair_tag,
	input wire logic [7:0] asid,
	output logic hit
);
	import tlbm_pkg::*;

	// Masked bits never take part in the compare
	wire [18:0] care = ~{3'h0, ent.mask};
	wire page_eq = ((ent.virtual_page_pair_tag ^ virtual_page_pair_tag) & care) == 19'h00000;

	// Dead entries are invisible to every lookup
	assign hit = !ent.dead && page_eq && (ent.g || ent.asid == asid);
endmodule
`default_nettype wire

// *** logic/tlbm_top.sv ***
/*
 * TLB maintenance engine with APB register access: probe, indexed read
 * and indexed write of a small fully associative TLB array.
 * Assumes an APB master on pclk, one instruction register whose write
 * launches an operation, and a core that reacts to the irq output.
 */
// Behaviour
// RULE1 - probe: major group, zero code, minor 0000001101, subgroup 111100
// RULE2 - read: major group, zero code, minor 0001001101, subgroup 111100
// RULE3 - write: major group, zero code, minor 0010001101, subgroup 111100
// RULE4 - probe compares the tag with all entries, loads pointer with hit
// RULE5 - probe miss sets the top bit of the entry pointer
// RULE6 - probe multi-match reported only in release three; writes always may
// RULE7 - read copies selected entry into tag, both mappings and mask
// RULE8 - read of invalidated entry with support 2 or 3 returns zeros
// RULE9 - read may zero page pair and frame bits under set mask bits
// RULE10 - read puts entry global bit into both mapping registers
// RULE11 - release three may flag multiple matches on a read
// RULE12 - software keeps entry pointer below implemented entry count
// RULE13 - any of the three without coprocessor access raises unusable
// RULE14 - write loads entry from registers unless invalidate is requested
// RULE15 - multiple matches found on a write raise a machine check
// RULE16 - write may zero page pair and frame bits under set mask bits
// RULE17 - write stores AND of both mapping global bits
// RULE18 - invalidate write only marks entry dead; no machine check
// RULE19 - each operation completes in one indivisible step
`timescale 1ns/1ps
`default_nettype none
module tlbm_top #(
	parameter int NUM_ENTRIES = 16,
	parameter int IDX_W = $clog2(NUM_ENTRIES)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	import tlbm_pkg::*;

	// Software-visible registers
	logic [31:0] insn_ff, nxt_insn;
	logic [31:0] tag_ff, nxt_tag;
	logic [31:0] even_ff, nxt_even;
	logic [31:0] odd_ff, nxt_odd;
	logic [31:0] pmask_ff, nxt_pmask;
	logic [31:0] index_ff, nxt_index;
	logic [31:0] cfg_ff, nxt_cfg;
	logic [ST_W-1:0] status_ff, nxt_status;
	logic [ST_W-1:0] irqmask_ff, nxt_irqmask;
	logic [31:0] prdata_ff;

	// The TLB array itself
	tlbm_entry_t tlb_ff [NUM_ENTRIES];

	// Bus phase decode
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire wr_acc = access && pwrite;
	wire sel_insn = paddr == OFF_INSN;
	wire sel_tag = paddr == OFF_TAG;
	wire sel_even = paddr == OFF_EVEN;
	wire sel_odd = paddr == OFF_ODD;
	wire sel_pmask = paddr == OFF_PMASK;
	wire sel_index = paddr == OFF_INDEX;
	wire sel_cfg = paddr == OFF_CFG;
	wire sel_status = paddr == OFF_STATUS;
	wire sel_irqmask = paddr == OFF_IRQMASK;
	wire mapped = sel_insn | sel_tag | sel_even | sel_odd | sel_pmask |
		sel_index | sel_cfg | sel_status | sel_irqmask;

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = prdata_ff;

	// Configuration fields
	wire [1:0] ie = cfg_ff[CFG_IE_LSB +: 2];
	wire ie_on = ie[1];
	wire rel3 = cfg_ff[CFG_REL3_BIT];
	wire cp0_en = cfg_ff[CFG_CP0EN_BIT];
	wire zmask = cfg_ff[CFG_ZMASK_BIT];

	// Current register fields
	wire [18:0] t_virtual_page_pair_tag = tag_ff[31:TAG_VIRTUAL_PAGE_PAIR_TAG_LSB];
	wire [7:0] t_asid = tag_ff[7:0];
	wire t_inv = tag_ff[TAG_INV_BIT];
	wire [15:0] m_mask = pmask_ff[PMASK_LSB +: 16];
	wire [IDX_W-1:0] idx = index_ff[IDX_W-1:0];

	// Instruction decode on the write data itself
	tlbm_op_t op;
	logic op_known;
	tlbm_decode u_decode (
		.insn(pwdata),
		.op(op),
		.known(op_known)
	);

	// One comparator per entry, all in parallel
	logic [NUM_ENTRIES-1:0] hits;
	for (genvar gi = 0; gi < NUM_ENTRIES; gi++) begin : g_match
		tlbm_match u_match (
			.ent(tlb_ff[gi]),
			.virtual_page_pair_tag(t_virtual_page_pair_tag),
			.asid(t_asid),
			.hit(hits[gi])
		);
	end

	// Lowest matching position wins the pointer
	logic [IDX_W-1:0] hit_idx;
	always_comb begin
		hit_idx = '0;
		for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
			if (hits[i]) begin
				hit_idx = IDX_W'(i);
			end
		end
	end

	// Multiple-match terms
	wire [NUM_ENTRIES-1:0] sel_onehot = NUM_ENTRIES'(1) << idx;
	wire hit_any = |hits;
	wire hit_multi = (hits & (hits - NUM_ENTRIES'(1))) != '0;
	wire hit_other = (hits & ~sel_onehot) != '0;

	// Operation launch and its gating
	wire op_go = wr_acc && sel_insn;
	wire tlb_op = op_go && op_known;
	wire cpu_evt = tlb_op && !cp0_en; // see RULE13
	wire run = tlb_op && cp0_en;
	wire run_probe = run && op == OP_PROBE;
	wire run_read = run && op == OP_READ;
	wire run_write = run && op == OP_WRITE;
	wire rsvd_evt = op_go && !op_known;

	// Invalidate request versus full load
	wire inv_write = ie_on && t_inv; // see RULE18
	wire full_write = run_write && !inv_write; // see RULE14

	// Machine check causes; probe and read only in release three
	wire mc_probe = run_probe && rel3 && hit_multi; // see RULE6
	wire mc_read = run_read && rel3 && hit_multi; // see RULE11
	wire mc_write = full_write && hit_other; // see RULE15
	wire mchk_evt = mc_probe || mc_read || mc_write;

	// Probe miss flag
	wire miss_evt = run_probe && !hit_any;
	wire done_evt = run && !mchk_evt;

	// Selected entry for a read
	tlbm_entry_t rd_ent;
	assign rd_ent = tlb_ff[idx];
	wire rd_dead = ie_on && rd_ent.dead; // see RULE8
	wire [18:0] rd_vmask = zmask ? ~{3'h0, rd_ent.mask} : 19'h7FFFF;
	wire [19:0] rd_pmask = zmask ? ~{4'h0, rd_ent.mask} : 20'hFFFFF;

	// Read results, global bit copied to both halves
	wire [31:0] rd_tag = rd_dead ? 32'h0000_0000 :
		{rd_ent.virtual_page_pair_tag & rd_vmask, 5'h00, rd_ent.asid}; // see RULE7
	wire [31:0] rd_even = rd_dead ? 32'h0000_0000 :
		{6'h00, rd_ent.pfn0 & rd_pmask, rd_ent.c0, rd_ent.d0, rd_ent.v0,
		rd_ent.g}; // see RULE9, RULE10
	wire [31:0] rd_odd = rd_dead ? 32'h0000_0000 :
		{6'h00, rd_ent.pfn1 & rd_pmask, rd_ent.c1, rd_ent.d1, rd_ent.v1,
		rd_ent.g}; // see RULE10
	wire [31:0] rd_mask = rd_dead ? 32'h0000_0000 :
		{3'h0, rd_ent.mask, 13'h0000};

	// Entry built for a write; masked bits optionally dropped
	wire [18:0] wr_vmask = zmask ? ~{3'h0, m_mask} : 19'h7FFFF;
	wire [19:0] wr_pmask = zmask ? ~{4'h0, m_mask} : 20'hFFFFF;
	tlbm_entry_t wr_ent;
	assign wr_ent.dead = 1'b0;
	assign wr_ent.virtual_page_pair_tag = t_virtual_page_pair_tag & wr_vmask; // see RULE16
	assign wr_ent.asid = t_asid;
	assign wr_ent.g = even_ff[MAP_G_BIT] & odd_ff[MAP_G_BIT]; // see RULE17
	assign wr_ent.mask = m_mask;
	assign wr_ent.pfn0 = even_ff[MAP_PFN_LSB +: 20] & wr_pmask; // see RULE16
	assign wr_ent.c0 = even_ff[MAP_C_LSB +: 3];
	assign wr_ent.d0 = even_ff[MAP_D_BIT];
	assign wr_ent.v0 = even_ff[MAP_V_BIT];
	assign wr_ent.pfn1 = odd_ff[MAP_PFN_LSB +: 20] & wr_pmask;
	assign wr_ent.c1 = odd_ff[MAP_C_LSB +: 3];
	assign wr_ent.d1 = odd_ff[MAP_D_BIT];
	assign wr_ent.v1 = odd_ff[MAP_V_BIT];

	// Probe pointer value: hit position or miss flag
	wire [31:0] probe_index = hit_any ? 32'(hit_idx) :
		32'(1) << INDEX_MISS_BIT; // see RULE4, RULE5

	// Register updates: read results commit in the same edge as the op
	wire ld_read = run_read && !mc_read; // see RULE19
	wire ld_probe = run_probe && !mc_probe;
	assign nxt_insn = op_go ? pwdata : insn_ff;
	assign nxt_tag = ld_read ? rd_tag :
		(wr_acc && sel_tag) ? pwdata : tag_ff;
	assign nxt_even = ld_read ? rd_even :
		(wr_acc && sel_even) ? pwdata : even_ff;
	assign nxt_odd = ld_read ? rd_odd :
		(wr_acc && sel_odd) ? pwdata : odd_ff;
	assign nxt_pmask = ld_read ? rd_mask :
		(wr_acc && sel_pmask) ? pwdata : pmask_ff;
	assign nxt_index = ld_probe ? probe_index :
		(wr_acc && sel_index) ? pwdata : index_ff;
	assign nxt_cfg = (wr_acc && sel_cfg) ? pwdata : cfg_ff;
	assign nxt_irqmask = (wr_acc && sel_irqmask) ?
		pwdata[ST_W-1:0] : irqmask_ff;

	// Sticky events; a new event wins over a same-cycle clear
	wire [ST_W-1:0] st_evt = {rsvd_evt, mchk_evt, cpu_evt, miss_evt,
		done_evt};
	wire [ST_W-1:0] st_clr = (wr_acc && sel_status) ?
		pwdata[ST_W-1:0] : '0;
	assign nxt_status = (status_ff & ~st_clr) | st_evt;

	// Level interrupt while any unmasked status bit stands
	assign irq = |(status_ff & irqmask_ff);

	// Read-back mux, captured in the setup cycle
	wire [31:0] rd_mux =
		sel_insn ? insn_ff :
		sel_tag ? tag_ff :
		sel_even ? even_ff :
		sel_odd ? odd_ff :
		sel_pmask ? pmask_ff :
		sel_index ? index_ff :
		sel_cfg ? cfg_ff :
		sel_status ? 32'(status_ff) :
		sel_irqmask ? 32'(irqmask_ff) : 32'h0000_0000;

	// Read data register; nothing changes between setup and access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= REG_RST;
		end else if (setup) begin
			prdata_ff <= rd_mux;
		end
	end

	// Last launched word, kept so software can see what ran
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			insn_ff <= REG_RST;
		end else begin
			insn_ff <= nxt_insn;
		end
	end

	// Translation tag; a read result lands on the op's own edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag_ff <= REG_RST;
		end else begin
			tag_ff <= nxt_tag;
		end
	end

	// Even page mapping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			even_ff <= REG_RST;
		end else begin
			even_ff <= nxt_even;
		end
	end

	// Odd page mapping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			odd_ff <= REG_RST;
		end else begin
			odd_ff <= nxt_odd;
		end
	end

	// Page size mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pmask_ff <= REG_RST;
		end else begin
			pmask_ff <= nxt_pmask;
		end
	end

	// Entry pointer; a probe and a bus write never share one edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_ff <= REG_RST;
		end else begin
			index_ff <= nxt_index;
		end
	end

	// Configuration; leaves reset with coprocessor access enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= CFG_RST;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	// Sticky status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= '0;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irqmask_ff <= '0;
		end else begin
			irqmask_ff <= nxt_irqmask;
		end
	end

	// Array update: whole entry in one edge, so no lookup sees a half
	// written entry. A detected conflict leaves the array untouched.
	// Pointer bits above the array width are dropped; the low bits pick the entry.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_ENTRIES; i++) begin
				tlb_ff[i] <= ENTRY_RST;
			end
		end else if (run_write && inv_write) begin
			tlb_ff[idx].dead <= 1'b1; // see RULE18, RULE12
		end else if (full_write && !mc_write) begin
			tlb_ff[idx] <= wr_ent; // see RULE14, RULE19
		end
	end

endmodule
`default_nettype wire

// *** sim/tlbm_assertions.sv ***
/* Checker for the TLB maintenance block, bound to its top module.
   Assumes the package offsets and one pclk domain with async presetn. */
`timescale 1ns/1ps
`default_nettype none
module tlbm_assertions import tlbm_pkg::*; #(
	parameter int NUM_ENTRIES = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	// Decoded view of the access phase
	wire logic acc = psel && penable;
	wire logic wr_acc = acc && pwrite;
	wire logic mapped = paddr[1:0] == 2'b00 && paddr <= OFF_IRQMASK;
	wire logic op_wr = wr_acc && paddr == OFF_INSN;
	wire logic known = pwdata inside {32'h037C, 32'h137C, 32'h237C};
	wire logic no_mc = pwdata inside {32'h037C, 32'h137C};
	wire logic cause = op_wr || (wr_acc && paddr == OFF_IRQMASK);
	logic [31:0] cfg_ff;
	logic [31:0] mask_ff;
	wire logic cpu_req = op_wr && known && !cfg_ff[CFG_CP0EN_BIT]
		&& mask_ff[ST_CPU];
	wire logic bad_req = op_wr && !known && mask_ff[ST_RSVD];
	wire logic done_req = op_wr && no_mc && cfg_ff[CFG_CP0EN_BIT]
		&& !cfg_ff[CFG_REL3_BIT] && mask_ff[ST_DONE];
	wire logic clr_all = wr_acc && paddr == OFF_STATUS && pwdata[4:0] == 5'h1F;

	// Shadows land on the same edge as the block's own registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= 32'h0000_0008;
			mask_ff <= 32'h0000_0000;
		end else if (wr_acc && paddr == OFF_CFG) begin
			cfg_ff <= pwdata;
		end else if (wr_acc && paddr == OFF_IRQMASK) begin
			mask_ff <= pwdata;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	pready_high_a: assert property (pready)
		else $error("pready low");
	slverr_map_a: assert property (pslverr == (acc && !mapped))
		else $error("pslverr wrong");
	unmapped_zero_a: assert property (
		acc && !pwrite && !mapped |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	prdata_hold_a: assert property (!psel |=> $stable(prdata))
		else $error("prdata moved while idle");
	irq_cause_a: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2))
		else $error("irq rose without cause");
	cpu_off_a: assert property (cpu_req |-> ##[1:2] irq)
		else $error("no unusable event");
	bad_insn_a: assert property (
		bad_req |-> ##[1:2] irq)
		else $error("no unknown event");
	op_done_a: assert property (done_req |-> ##[1:2] irq)
		else $error("no done event");
	mask_off_a: assert property (mask_ff[4:0] == 5'h0 |-> !irq)
		else $error("irq while masked");
	status_clr_a: assert property (clr_all |=> !irq)
		else $error("irq after clear");
	cover property (done_req);
	cover property (cpu_req);
	cover property (acc && !mapped);
endmodule
bind tlbm_top tlbm_assertions #(.NUM_ENTRIES(NUM_ENTRIES)) tlbm_assertions_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// *** sim/tlbm_core_model.sv ***
/* Core-side model: the APB master that issues register transfers.
   Assumes a slave answering with pready; waits are cut by the bench. */
`timescale 1ns/1ps
`default_nettype none
module tlbm_core_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// One transfer; released lines show the inverse so stale data is caught
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// *** sim/test_tlb_maintenance_ops.sv ***
/* Self-checking bench for the TLB maintenance block over APB.
   Assumes the core model drives the bus and a four-entry array. */
`timescale 1ns/1ps
`default_nettype none
module test_tlb_maintenance_ops;
	import tlbm_pkg::*;
	localparam logic [31:0] PRB = 32'h0000_037C;
	localparam logic [31:0] RDO = 32'h0000_137C;
	localparam logic [31:0] WRI = 32'h0000_237C;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	wire logic psel, penable, pwrite, pready, pslverr, irq;
	wire logic [7:0] paddr;
	wire logic [31:0] pwdata, prdata;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rdat;
	logic rerr;

	always #12.5 pclk = ~pclk;

	// Small array keeps the run short
	tlbm_top #(.NUM_ENTRIES(4)) tlbm_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));
	tlbm_core_model tlbm_core_model_inst (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	task conclude;
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			conclude();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		tlbm_core_model_inst.xfer(1'b1, a, d, rdat, rerr);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		tlbm_core_model_inst.xfer(1'b0, a, 32'h0, rdat, rerr);
		chk(rdat, exp);
	endtask
	// irq is sampled mid-cycle, away from the edge that moves it
	task irq_is(input logic e);
		@(negedge pclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	// Launch, check the events raised, then clear them all
	task op(input logic [31:0] w, input logic [31:0] st);
		wr(OFF_INSN, w);
		rd(OFF_STATUS, st);
		irq_is(st != 32'h0);
		wr(OFF_STATUS, 32'h1F);
	endtask
	task put(input logic [31:0] t, e, o, m, i);
		wr(OFF_TAG, t);
		wr(OFF_EVEN, e);
		wr(OFF_ODD, o);
		wr(OFF_PMASK, m);
		wr(OFF_INDEX, i);
	endtask
	// Registers are scrambled first so a read that does nothing shows
	task get(input logic [31:0] i, t, e, o, m);
		put(32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, i);
		op(RDO, 32'h1);
		rd(OFF_TAG, t);
		rd(OFF_EVEN, e);
		rd(OFF_ODD, o);
		rd(OFF_PMASK, m);
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CFG, 32'h0000_0008);
		rd(OFF_STATUS, 32'h0);
		rd(OFF_INDEX, 32'h0);
		wr(OFF_IRQMASK, 32'h1F);
		// Odd global clear, so the stored global bit is clear
		put(32'h2468_A005, 32'h0002_AF1F, 32'h0003_7BDE, 32'h0, 32'h1);
		op(WRI, 32'h1);
		get(32'h1, 32'h2468_A005, 32'h0002_AF1E, 32'h0003_7BDE, 32'h0);
		put(32'h2468_C007, 32'h0002_AF1F, 32'h0003_7BDF, 32'h0, 32'h2);
		op(WRI, 32'h1);
		get(32'h2, 32'h2468_C007, 32'h0002_AF1F, 32'h0003_7BDF, 32'h0);
		// Masked page bits zeroed on write and read
		wr(OFF_CFG, 32'h18);
		put(32'h4468_E009, 32'h0002_AFDF, 32'h0003_7BDF, 32'h6000, 32'h3);
		op(WRI, 32'h1);
		get(32'h3, 32'h4468_8009, 32'h0002_AF1F, 32'h0003_7B1F, 32'h6000);
		// Global entry hits in any space, private one only in its own
		wr(OFF_TAG, 32'h2468_C000);
		op(PRB, 32'h1);
		rd(OFF_INDEX, 32'h2);
		wr(OFF_TAG, 32'h2468_A000);
		op(PRB, 32'h3);
		rd(OFF_INDEX, 32'h8000_0000);
		// A duplicate of entry 1 at slot 0 is refused and left unwritten
		put(32'h2468_A005, 32'h0002_AF1F, 32'h0003_7BDE, 32'h0, 32'h0);
		op(WRI, 32'h8);
		op(PRB, 32'h1);
		rd(OFF_INDEX, 32'h1);
		// Global twin of entry 1 in slot 0: multi-match only in release three
		put(32'h2468_A006, 32'h0000_0041, 32'h0000_0041, 32'h0, 32'h0);
		op(WRI, 32'h1);
		wr(OFF_TAG, 32'h2468_A005);
		wr(OFF_INDEX, 32'h3);
		op(PRB, 32'h1);
		rd(OFF_INDEX, 32'h0);
		wr(OFF_INDEX, 32'h3);
		wr(OFF_CFG, 32'h0C);
		op(PRB, 32'h8);
		rd(OFF_INDEX, 32'h3);
		op(RDO, 32'h8);
		rd(OFF_TAG, 32'h2468_A005);
		// Invalidate entry 2, then it reads as zeros and no longer matches
		wr(OFF_CFG, 32'h0A);
		put(32'h2468_C400, 32'h0, 32'h0, 32'h0, 32'h2);
		op(WRI, 32'h1);
		get(32'h2, 32'h0, 32'h0, 32'h0, 32'h0);
		wr(OFF_TAG, 32'h2468_C000);
		op(PRB, 32'h3);
		// No coprocessor access
		wr(OFF_CFG, 32'h0);
		op(PRB, 32'h4);
		op(RDO, 32'h4);
		op(WRI, 32'h4);
		// Near-miss encodings are not operations
		wr(OFF_CFG, 32'h08);
		op(32'h0001_037C, 32'h10);
		op(32'h0400_137C, 32'h10);
		op(32'h0000_237D, 32'h10);
		op(32'h0000_337C, 32'h10);
		// Masked event stays quiet until unmasked, then clears
		wr(OFF_IRQMASK, 32'h0);
		wr(OFF_INSN, 32'h0);
		rd(OFF_STATUS, 32'h10);
		irq_is(1'b0);
		wr(OFF_IRQMASK, 32'h1F);
		irq_is(1'b1);
		wr(OFF_STATUS, 32'h1F);
		irq_is(1'b0);
		rd(8'h24, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		conclude();
	end
endmodule
`default_nettype wire
